// *** crc_consts.svh ***
// Constants of the card reader command logic: offsets, fields, codes.
// Assumes bit n of an instruction or command word is vector bit [n].
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH
// Wishbone byte offsets.
`define CRC_ADR_INSTR 8'h00
`define CRC_ADR_INREG 8'h04
// Instruction word fields.
`define CRC_I_OPC 5:0
`define CRC_I_GRP 7:6
`define CRC_I_RSEL 11:8
`define CRC_I_UNIT 15:12
`define CRC_I_CMD 31:16
`define CRC_OPC_OUTCMD 6'h02
`define CRC_OPC_INSTAT 6'h12
`define CRC_OPC_INDATA 6'h32
// Command word fields and kinds.
`define CRC_CW_KIND 1:0
`define CRC_KIND_NOOP 2'h0
`define CRC_KIND_READ 2'h1
`define CRC_KIND_CTRL 2'h2
`define CRC_CW_DCON 2
`define CRC_CW_SCON 3
`define CRC_CW_ENDBLK 4
`define CRC_CW_MODE 5
// Status word bits.
`define CRC_ST_NOERR 0
`define CRC_ST_OVF 1
`define CRC_ST_LDCHK 2
`define CRC_ST_INOP 3
`define CRC_ST_BUSY 7
`define CRC_ST_DRDYN 8
`define CRC_ST_HOPPER 9
`define CRC_ST_HOLD 12
`define CRC_ST_PICKF 13
// Column rows and translated word layout.
`define CRC_ROW12 11
`define CRC_ROW11 10
`define CRC_ROW0 9
`define CRC_ROW9 8
`define CRC_ROW8 7
`define CRC_TR_R12 8
`define CRC_TR_R11 9
`define CRC_TR_R0 10
`define CRC_TR_ENC 13:11
`define CRC_TR_R8 14
`define CRC_TR_R9 15
`define CRC_RES_RSEL 19:16
`define CRC_COLUMNS 7'd80
`define CRC_GROUP_DFLT 2'h0
`define CRC_UNIT_DFLT 4'h5
`endif

// *** crc_pkg.sv ***
// Types of the card reader command logic.
// Assumes crc_consts.svh is not needed here; widths are fixed.
package crc_pkg;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } crc_wbin_s;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } crc_wbout_s;
   typedef struct packed {
      logic ready;
      logic cardIn;
      logic strobe;
      logic [11:0] col;
      logic lightDark;
      logic inoperable;
      logic hopperEmpty;
      logic pickFail;
      logic hold;
   } crc_rdr_s;
   typedef enum logic [1:0] {
      CARD_IDLE = 2'b00,
      CARD_PICK = 2'b01,
      CARD_READ = 2'b10
   } crc_card_e;
   typedef struct packed {
      crc_rdr_s syncA;
      crc_rdr_s syncB;
      crc_rdr_s prev;
      crc_card_e card;
      logic xferEn;
      logic binMode;
      logic dataReady;
      logic overflow;
      logic ldLatch;
      logic pfLatch;
      logic dataCon;
      logic svcCon;
      logic dataReq;
      logic svcReq;
      logic [6:0] colCount;
      logic [15:0] column;
      logic [31:0] lastInstr;
      logic [31:0] inReg;
      crc_wbout_s wb;
   } crc_state_s;
endpackage

// *** crc_command_logic.sv ***
// Card reader command logic: instruction decode, card flow, data and status.
// Assumes a Wishbone classic master on clk and reader pins from outside.
// What this block does
// - Act only on matching group and unit
// - Read bit 2 connects data interrupt
// - Read bit 3 connects service interrupt
// - Read bit 5 picks binary or translate
// - Read command with bit 4 set starts card motion
// - One data interrupt per column
// - Service interrupt at card end, fault
// - Terminate halts transfer, clears data request
// - Terminate with bit 4 raises end-of-block interrupt
// - No-op clears status, applies connect bits
// - No-op bit 3 clear drops service request
// - Data-in delivers current column
// - Binary mode delivers raw punches
// - Translate mode gives eight-bit code
// - Rows one to seven binary encoded
// - Input status returns status word
// - Data ready shown at status bit 8
// - Register I/O mode only
// - Status bit 8 low when column waits
// - Late data-in sets overflow, stops per-column data requests
// - Status bit 7 shows busy
// - Read starts only while reader ready
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "crc_consts.svh"
module crc_command_logic #(
   parameter logic [1:0] GROUP = `CRC_GROUP_DFLT,
   parameter logic [3:0] UNIT = `CRC_UNIT_DFLT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic icbClear,
   // Wishbone slave
   input wire crc_pkg::crc_wbin_s wbIn,
   output crc_pkg::crc_wbout_s wbOut,
   // Card reader pins
   input wire crc_pkg::crc_rdr_s rdrIn,
   output logic pickCmd,
   // Interrupt requests and their update-queue acknowledges
   input wire logic dataIntAck,
   input wire logic svcIntAck,
   output logic dataIntReq,
   output logic svcIntReq
);
   import crc_pkg::*;

   crc_state_s s_q;
   crc_state_s s_d;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] rowEncode(input logic [6:0] r);
      logic [2:0] e;
      e = 3'h0;
      for (int i = 0; i < 7; i++)
      begin
         if (r[i])
         begin
            e = 3'(i + 1);
         end
      end
      return e;
   endfunction

   function automatic logic [15:0] formatColumn(input logic bin, input logic [11:0] c);
      logic [15:0] w;
      w = 16'h0000;
      if (bin)
      begin
         w[11:0] = c;
      end
      else
      begin
         w[`CRC_TR_R12] = c[`CRC_ROW12];
         w[`CRC_TR_R11] = c[`CRC_ROW11];
         w[`CRC_TR_R0] = c[`CRC_ROW0];
         w[`CRC_TR_R8] = c[`CRC_ROW8];
         w[`CRC_TR_R9] = c[`CRC_ROW9];
         w[`CRC_TR_ENC] = rowEncode(c[6:0]);
      end
      return w;
   endfunction

   // ------------------------------------------------------------
   // Decode and status
   // ------------------------------------------------------------
   logic taken;
   logic instrWrite;
   logic addrHit;
   logic [15:0] statusWord;
   logic [15:0] cmdWord;
   logic isRead;
   logic isCtrl;
   logic isNoop;
   logic strobeFall;
   logic strobeRise;
   logic cardEnd;
   logic cardStart;
   logic fault;
   logic faultRise;

   always_comb
   begin
      taken = wbIn.cyc && wbIn.stb && !s_q.wb.ack;
      instrWrite = taken && wbIn.we && (wbIn.adr == `CRC_ADR_INSTR) && (&wbIn.sel);
      // The register selector bits 11:8 take no part in this match.
      addrHit = (wbIn.dat[`CRC_I_GRP] == GROUP) && (wbIn.dat[`CRC_I_UNIT] == UNIT);
      cmdWord = wbIn.dat[`CRC_I_CMD];
      isRead = instrWrite && addrHit && (wbIn.dat[`CRC_I_OPC] == `CRC_OPC_OUTCMD)
               && (cmdWord[`CRC_CW_KIND] == `CRC_KIND_READ) && cmdWord[`CRC_CW_ENDBLK];
      isCtrl = instrWrite && addrHit && (wbIn.dat[`CRC_I_OPC] == `CRC_OPC_OUTCMD)
               && (cmdWord[`CRC_CW_KIND] == `CRC_KIND_CTRL);
      isNoop = instrWrite && addrHit && (wbIn.dat[`CRC_I_OPC] == `CRC_OPC_OUTCMD)
               && (cmdWord[`CRC_CW_KIND] == `CRC_KIND_NOOP);
      strobeRise = s_q.syncB.strobe && !s_q.prev.strobe;
      strobeFall = !s_q.syncB.strobe && s_q.prev.strobe;
      cardStart = s_q.syncB.cardIn && !s_q.prev.cardIn;
      cardEnd = !s_q.syncB.cardIn && s_q.prev.cardIn;
      fault = s_q.syncB.lightDark || s_q.syncB.inoperable || s_q.syncB.pickFail;
      faultRise = fault && !(s_q.prev.lightDark || s_q.prev.inoperable || s_q.prev.pickFail);
      statusWord = 16'h0000;
      statusWord[`CRC_ST_OVF] = s_q.overflow;
      statusWord[`CRC_ST_LDCHK] = s_q.ldLatch;
      statusWord[`CRC_ST_INOP] = s_q.syncB.inoperable || s_q.pfLatch;
      statusWord[`CRC_ST_NOERR] = !(s_q.overflow || s_q.ldLatch || statusWord[`CRC_ST_INOP]);
      statusWord[`CRC_ST_BUSY] = (s_q.card != CARD_IDLE);
      statusWord[`CRC_ST_DRDYN] = !s_q.dataReady;
      statusWord[`CRC_ST_HOPPER] = s_q.syncB.hopperEmpty;
      statusWord[`CRC_ST_HOLD] = s_q.syncB.hold;
      statusWord[`CRC_ST_PICKF] = s_q.pfLatch;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic rdInstr;
      logic dataEvt;
      logic svcEvt;
      crc_wbout_s wbNext;
      rdInstr = 1'b0;
      dataEvt = 1'b0;
      svcEvt = 1'b0;
      wbNext = '0;
      s_d = s_q;
      // Pins pass two flip-flops; prev holds the second stage's last value.
      s_d.syncA = rdrIn;
      s_d.syncB = s_q.syncA;
      s_d.prev = s_q.syncB;
      if (s_q.syncB.lightDark)
      begin
         s_d.ldLatch = 1'b1;
      end
      if (s_q.syncB.pickFail)
      begin
         s_d.pfLatch = 1'b1;
      end

      // Bus answer.
      s_d.wb.ack = taken;
      s_d.wb.dat = 32'h0000_0000;
      if (taken && !wbIn.we)
      begin
         if (wbIn.adr == `CRC_ADR_INSTR)
         begin
            s_d.wb.dat = s_q.lastInstr;
         end
         else if (wbIn.adr == `CRC_ADR_INREG)
         begin
            s_d.wb.dat = s_q.inReg;
         end
      end
      if (instrWrite)
      begin
         s_d.lastInstr = wbIn.dat;
      end

      // Card flow.
      case (s_q.card)
         CARD_IDLE:
         begin
            if (isRead && s_q.syncB.ready)
            begin
               s_d.card = CARD_PICK;
               s_d.xferEn = 1'b1;
               s_d.colCount = 7'd0;
               s_d.overflow = 1'b0;
            end
         end
         CARD_PICK:
         begin
            if (cardStart)
            begin
               s_d.card = CARD_READ;
            end
         end
         CARD_READ:
         begin
            if (cardEnd)
            begin
               s_d.card = CARD_IDLE;
               s_d.xferEn = 1'b0;
               svcEvt = 1'b1;
               if (s_q.dataReady)
               begin
                  s_d.overflow = 1'b1;
               end
            end
         end
         default:
         begin
            s_d.card = CARD_IDLE;
         end
      endcase
      if (isRead && s_q.syncB.ready && (s_q.card == CARD_IDLE))
      begin
         s_d.dataCon = cmdWord[`CRC_CW_DCON];
         s_d.svcCon = cmdWord[`CRC_CW_SCON];
         s_d.binMode = cmdWord[`CRC_CW_MODE];
      end

      // Column transfer: a waiting column at the next strobe is overflow.
      if (strobeRise && s_q.dataReady && (s_q.card == CARD_READ))
      begin
         s_d.overflow = 1'b1;
      end
      if (strobeFall && s_q.xferEn && !s_q.overflow && !s_d.overflow
          && (s_q.colCount < `CRC_COLUMNS))
      begin
         s_d.dataReady = 1'b1;
         s_d.colCount = s_q.colCount + 7'd1;
         s_d.column = formatColumn(s_q.binMode, s_q.syncB.col);
         dataEvt = 1'b1;
      end

      // Input instructions; register I/O only, no direct memory path.
      if (instrWrite && addrHit && (wbIn.dat[`CRC_I_OPC] == `CRC_OPC_INDATA))
      begin
         rdInstr = 1'b1;
         s_d.inReg = {12'h000, wbIn.dat[`CRC_I_RSEL], s_q.column};
         // A column taken in this same cycle stays ready rather than being lost.
         s_d.dataReady = dataEvt;
      end
      if (instrWrite && addrHit && (wbIn.dat[`CRC_I_OPC] == `CRC_OPC_INSTAT))
      begin
         s_d.inReg = {12'h000, wbIn.dat[`CRC_I_RSEL], statusWord};
      end

      // Terminate and end of block.
      if (isCtrl && cmdWord[`CRC_CW_MODE])
      begin
         s_d.xferEn = 1'b0;
         s_d.dataReady = 1'b0;
         s_d.dataReq = 1'b0;
         if (cmdWord[`CRC_CW_ENDBLK])
         begin
            dataEvt = 1'b1;
         end
      end

      // No-op clears overflow, the light-dark and pick-fail latches and data ready.
      if (isNoop)
      begin
         s_d.overflow = 1'b0;
         // A fault still present at the clear keeps its latch set.
         s_d.ldLatch = s_q.syncB.lightDark;
         s_d.pfLatch = s_q.syncB.pickFail;
         s_d.dataReady = 1'b0;
         s_d.dataCon = cmdWord[`CRC_CW_DCON];
         s_d.svcCon = cmdWord[`CRC_CW_SCON];
      end

      if (s_q.card == CARD_IDLE && !isRead && !rdInstr && !cardEnd)
      begin
         s_d.dataReady = 1'b0;
      end

      if (faultRise)
      begin
         svcEvt = 1'b1;
      end

      // Requests: acknowledge clears, a new event in the same cycle wins.
      if (dataIntAck)
      begin
         s_d.dataReq = 1'b0;
      end
      if (svcIntAck)
      begin
         s_d.svcReq = 1'b0;
      end
      if (!s_d.dataCon)
      begin
         s_d.dataReq = 1'b0;
      end
      else if (dataEvt)
      begin
         s_d.dataReq = 1'b1;
      end
      if (!s_d.svcCon)
      begin
         s_d.svcReq = 1'b0;
      end
      else if (svcEvt)
      begin
         s_d.svcReq = 1'b1;
      end

      if (icbClear)
      begin
         wbNext = s_d.wb;
         s_d = '0;
         s_d.syncA = rdrIn;
         s_d.syncB = s_q.syncA;
         s_d.prev = s_q.syncB;
         s_d.wb = wbNext;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   always_comb
   begin
      wbOut = s_q.wb;
      // Only the pick state has code bit 0 set, so the pin is a flip-flop itself.
      pickCmd = s_q.card[0];
      dataIntReq = s_q.dataReq;
      svcIntReq = s_q.svcReq;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   wb_ack_pulse_a: assert property (s_q.wb.ack |=> !s_q.wb.ack)
      else $error("ack held for two cycles");
   addr_match_a: assert property (instrWrite && !addrHit
      && s_q.card == CARD_IDLE && !icbClear |=> s_q.card == CARD_IDLE)
      else $error("foreign unit started a read");
   pick_start_a: assert property (isRead && s_q.syncB.ready
      && s_q.card == CARD_IDLE && !icbClear |=> pickCmd && s_q.xferEn)
      else $error("read command did not start pick");
   ready_gate_a: assert property (isRead && !s_q.syncB.ready
      && s_q.card == CARD_IDLE |=> !pickCmd)
      else $error("pick started while reader not ready");
   mode_latch_a: assert property (isRead && s_q.syncB.ready
      && s_q.card == CARD_IDLE && !icbClear |=> s_q.binMode == $past(cmdWord[`CRC_CW_MODE]))
      else $error("mode bit not latched");
   term_stop_a: assert property (isCtrl && cmdWord[`CRC_CW_MODE]
      |=> !s_q.xferEn && !s_q.dataReady)
      else $error("terminate left transfer running");
   data_disc_a: assert property (!s_q.dataCon |-> !dataIntReq)
      else $error("data request while disconnected");
   svc_disc_a: assert property (!s_q.svcCon |-> !svcIntReq)
      else $error("service request while disconnected");
   busy_bit_a: assert property (statusWord[`CRC_ST_BUSY]
      == (pickCmd || s_q.card == CARD_READ))
      else $error("busy status disagrees with card flow");
   noop_clr_a: assert property (isNoop && !s_q.syncB.lightDark
      && !s_q.syncB.pickFail |=> !s_q.overflow && !s_q.ldLatch && !s_q.pfLatch)
      else $error("no-op left status set");
   col_fill_a: assert property (strobeFall && s_q.xferEn && !s_q.overflow
      && !strobeRise && s_q.colCount < `CRC_COLUMNS && !icbClear && !isCtrl && !isNoop
      |=> s_q.dataReady ##0 s_q.colCount == $past(s_q.colCount) + 7'd1)
      else $error("column not taken on strobe");
   ovf_block_a: assert property (s_q.overflow && !isNoop && !isRead
      |=> !$rose(s_q.dataReady))
      else $error("data ready rose during overflow");
endmodule // crc_command_logic

// *** crc_reader_model.sv ***
// Behavioural card reader that feeds the command logic its pins.
// Assumes the bench sets colVal, nCols and gap before each pick command.
`timescale 1ns/100ps
module crc_reader_model (
   // Bench controls
   input wire logic clk,
   input wire logic ready,
   input wire logic [11:0] colVal,
   input wire logic [6:0] nCols,
   input wire logic [7:0] gap,
   input wire logic fault,
   // Reader pins
   input wire logic pickCmd,
   output crc_pkg::crc_rdr_s rdr
);
   import crc_pkg::*;
   logic cardIn;
   logic strobe;
   logic [11:0] col;
   assign rdr = '{ready: ready, cardIn: cardIn, strobe: strobe, col: col, inoperable: fault,
                  default: 1'b0};
   initial
   begin
      cardIn = 1'b0;
      strobe = 1'b0;
      col = 12'h000;
      forever
      begin
         @(posedge clk);
         if (pickCmd === 1'b1 && ready === 1'b1)
         begin
            repeat (8) @(posedge clk);
            cardIn <= 1'b1;
            repeat (10) @(posedge clk);
            for (int k = 0; k < nCols; k++)
            begin
               col <= colVal;
               repeat (2) @(posedge clk);
               strobe <= 1'b1;
               repeat (4) @(posedge clk);
               strobe <= 1'b0;
               repeat (3) @(posedge clk);
               // Released data lines show the inverse so a late sample is caught.
               col <= ~colVal;
               repeat (gap) @(posedge clk);
            end
            cardIn <= 1'b0;
            repeat (8) @(posedge clk);
         end
      end
   end
endmodule // crc_reader_model

// *** crc_command_logic_tb_top.sv ***
// Self-checking bench for the card reader command logic.
// Assumes the reader model on the far side and a classic Wishbone master here.
`timescale 1ns/100ps
`include "crc_consts.svh"
module crc_command_logic_tb_top;
   import crc_pkg::*;
   localparam logic [1:0] GRP = 2'h2;
   localparam logic [3:0] UNT = 4'h9;
   localparam logic [3:0] REGSEL = 4'hA;
   localparam logic [5:0] OC = `CRC_OPC_OUTCMD;
   logic clk, resetn, icbClear, pickCmd, ready;
   logic fault;
   logic dataIntAck, svcIntAck, dataIntReq, svcIntReq;
   crc_wbin_s wbIn;
   crc_wbout_s wbOut;
   crc_rdr_s rdr;
   logic [11:0] colVal;
   logic [6:0] nCols;
   logic [7:0] gap;
   logic [31:0] rd;
   int nErrors, samplesChecked;
   crc_command_logic #(.GROUP(GRP), .UNIT(UNT)) i_crc_command_logic (.clk(clk),
      .resetn(resetn), .icbClear(icbClear), .wbIn(wbIn), .wbOut(wbOut), .rdrIn(rdr),
      .pickCmd(pickCmd), .dataIntAck(dataIntAck), .svcIntAck(svcIntAck),
      .dataIntReq(dataIntReq), .svcIntReq(svcIntReq));
   crc_reader_model i_crc_reader_model (.clk(clk), .ready(ready), .colVal(colVal),
      .nCols(nCols), .gap(gap), .fault(fault), .pickCmd(pickCmd), .rdr(rdr));
   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic endSim;
      $display("checks %0d mismatches %0d", samplesChecked, nErrors);
      if (nErrors == 0 && samplesChecked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp)
      begin
         nErrors++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wbAcc(input logic we, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      wbIn <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      do
      begin
         @(posedge clk);
         t++;
      end
      while (wbOut.ack !== 1'b1 && t < 50);
      rd = wbOut.dat;
      wbIn <= '0;
      chk(t < 50, 1'b1);
   endtask
   task automatic ins(input logic [1:0] g, input logic [3:0] u, input logic [5:0] o,
                      input logic [15:0] c);
      wbAcc(1'b1, `CRC_ADR_INSTR, {c, u, REGSEL, g, o});
   endtask
   task automatic inWord(input logic [5:0] o);
      ins(GRP, UNT, o, 16'h0000);
      wbAcc(1'b0, `CRC_ADR_INREG, 32'h0);
   endtask
   task automatic stat(input logic [15:0] exp);
      inWord(`CRC_OPC_INSTAT);
      chk(rd, {12'h000, REGSEL, exp});
   endtask
   task automatic dataIn(input logic [15:0] exp);
      inWord(`CRC_OPC_INDATA);
      chk(rd, {12'h000, REGSEL, exp});
   endtask
   // Polls the status word until bit b reads v, with a bounded count.
   task automatic pollBit(input int b, input logic v);
      int t;
      t = 0;
      do
      begin
         inWord(`CRC_OPC_INSTAT);
         t++;
      end
      while (rd[b] !== v && t < 2000);
      chk(rd[b], v);
   endtask
   task automatic waitReq(input logic svc);
      int t;
      t = 0;
      while ((svc ? svcIntReq : dataIntReq) !== 1'b1 && t < 2000)
      begin
         @(posedge clk);
         t++;
      end
      chk(svc ? svcIntReq : dataIntReq, 1'b1);
   endtask
   task automatic pulse(input logic svc);
      if (svc)
         svcIntAck <= 1'b1;
      else
         dataIntAck <= 1'b1;
      @(posedge clk);
      svcIntAck <= 1'b0;
      dataIntAck <= 1'b0;
      @(posedge clk);
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      nErrors++;
      $display("FAIL at %0t: watchdog expired", $time);
      endSim();
   end
   initial
   begin
      resetn = 1'b0;
      icbClear = 1'b0;
      wbIn = '0;
      dataIntAck = 1'b0;
      svcIntAck = 1'b0;
      ready = 1'b1;
      fault = 1'b0;
      colVal = 12'h000;
      nCols = 7'd80;
      gap = 8'd30;
      nErrors = 0;
      samplesChecked = 0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk({pickCmd, dataIntReq, svcIntReq}, 32'h0);
      stat(16'h0101);
      wbAcc(1'b0, `CRC_ADR_INSTR, 32'h0);
      chk(rd, {16'h0000, UNT, REGSEL, GRP, `CRC_OPC_INSTAT});
      wbAcc(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      ins(GRP ^ 2'h1, UNT, OC, 16'h003D);
      ins(GRP, UNT ^ 4'h1, OC, 16'h003D);
      ready <= 1'b0;
      // The ready pin needs its two synchroniser stages before a command sees it.
      repeat (3) @(posedge clk);
      ins(GRP, UNT, OC, 16'h003D);
      repeat (10) @(posedge clk);
      chk(pickCmd, 1'b0);
      stat(16'h0101);
      ready <= 1'b1;
      repeat (3) @(posedge clk);
      $display("test decode done");
      colVal <= 12'hA5C;
      ins(GRP, UNT, OC, 16'h003D);
      @(posedge clk);
      chk(pickCmd, 1'b1);
      for (int k = 0; k < 80; k++)
      begin
         waitReq(1'b0);
         if (k == 0)
            stat(16'h0081);
         pulse(1'b0);
         dataIn({4'h0, 12'hA5C});
      end
      waitReq(1'b1);
      pulse(1'b1);
      chk(svcIntReq, 1'b0);
      pollBit(7, 1'b0);
      $display("test binary card done");
      colVal <= 12'hA94;
      nCols <= 7'd2;
      ins(GRP, UNT, OC, 16'h0019);
      for (int k = 0; k < 2; k++)
      begin
         pollBit(8, 1'b0);
         chk(dataIntReq, 1'b0);
         dataIn(16'h6D00);
      end
      pollBit(7, 1'b0);
      pulse(1'b1);
      $display("test translate card done");
      colVal <= 12'h001;
      nCols <= 7'd3;
      ins(GRP, UNT, OC, 16'h0039);
      pollBit(7, 1'b0);
      stat(16'h0102);
      chk(svcIntReq, 1'b1);
      ins(GRP, UNT, OC, 16'h0000);
      stat(16'h0101);
      chk(svcIntReq, 1'b0);
      $display("test overflow done");
      colVal <= 12'h3C3;
      nCols <= 7'd80;
      ins(GRP, UNT, OC, 16'h0035);
      waitReq(1'b0);
      ins(GRP, UNT, OC, 16'h0022);
      @(posedge clk);
      chk(dataIntReq, 1'b0);
      stat(16'h0181);
      repeat (100) @(posedge clk);
      chk(dataIntReq, 1'b0);
      ins(GRP, UNT, OC, 16'h0032);
      @(posedge clk);
      chk(dataIntReq, 1'b1);
      pulse(1'b0);
      pollBit(7, 1'b0);
      chk(svcIntReq, 1'b0);
      $display("test terminate done");
      nCols <= 7'd1;
      ins(GRP, UNT, OC, 16'h003D);
      icbClear <= 1'b1;
      @(posedge clk);
      icbClear <= 1'b0;
      @(posedge clk);
      chk({pickCmd, dataIntReq, svcIntReq}, 32'h0);
      stat(16'h0101);
      ins(GRP, UNT, OC, 16'h0008);
      fault <= 1'b1;
      waitReq(1'b1);
      stat(16'h0108);
      fault <= 1'b0;
      pulse(1'b1);
      chk(svcIntReq, 1'b0);
      $display("test clear and fault done");
      endSim();
   end
endmodule // crc_command_logic_tb_top
